//--- inc/pio_pkg.sv
// Purpose: Constants for the programmable pin bank.
// Assumes: 16-bit register words in a 256-byte register block.
// Notes:   Offsets are byte addresses within the block.
package pio_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int          PIO_NUM_PINS   = 32;
  localparam int          PIO_ADDR_W     = 8;
  localparam int          PIO_DATA_W     = 16;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  PIO_MODE0_OFS  = 8'h70;
  localparam logic [7:0]  PIO_DIR0_OFS   = 8'h72;
  localparam logic [7:0]  PIO_DATA0_OFS  = 8'h74;
  localparam logic [7:0]  PIO_MODE1_OFS  = 8'h76;
  localparam logic [7:0]  PIO_DIR1_OFS   = 8'h78;
  localparam logic [7:0]  PIO_DATA1_OFS  = 8'h7a;
  localparam logic [7:0]  PIO_PULLDN0_OFS = 8'h7c;
  localparam logic [7:0]  PIO_PULLDN1_OFS = 8'h7e;
  localparam logic [7:0]  PIO_STATUS_OFS = 8'h6e;

  // ---------------------------------------------------------------------------
  // Reset values (mode 1 = output, dir 1 = input, or open-drain with mode 1)
  // ---------------------------------------------------------------------------
  localparam logic [31:0] PIO_MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] PIO_DIR_RST    = 32'hffff_ffff;
  localparam logic [31:0] PIO_DATA_RST   = 32'h0000_0000;
  // Pins 3..9 start in normal function.
  localparam logic [31:0] PIO_NORM_RST   = 32'h0000_03f8;
  // Pins 1 and 10 start as input with pull-down.
  localparam logic [31:0] PIO_PDN_RST    = 32'h0000_0402;
  // Pins reverted to normal operation by the bus override strap.
  localparam logic [31:0] PIO_OVR_MASK   = 32'h2400_0000;
  // Address-high pins 7..9.
  localparam logic [31:0] PIO_ADDR_HI    = 32'h0000_0380;
  // Direction, data strobe and ready pins 4..6.
  localparam logic [31:0] PIO_BUS_CTL    = 32'h0000_0070;
  // Ready pin, which alone of the normal-function pins may pull down.
  localparam int          PIO_READY_PIN  = 6;

  // ---------------------------------------------------------------------------
  // Pin configuration encoding
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PIO_CFG_NORMAL  = 3'b000,
    PIO_CFG_IN_PU   = 3'b001,
    PIO_CFG_IN_PD   = 3'b010,
    PIO_CFG_IN      = 3'b011,
    PIO_CFG_OUT     = 3'b100,
    PIO_CFG_OUT_OD  = 3'b101
  } pio_cfg_t;

endpackage

//--- verilog/pio_bank.sv
// Purpose: Thirty-two pin programmable I/O bank with register port.
// Assumes: Synchronous pin inputs; one 250 MHz clock; 16-bit word registers.
// Notes:   Mode/direction pair per pin, plus a pull-down select per pin.
`timescale 1ns/1ns

// Function
// - Thirty-two pins individually selectable as general I/O.
// - General I/O disconnects peripheral drive and sampling.
// - Input or output, with pull-up or pull-down.
// - Open-drain output drives low only.
// - Reset restores each pin's own default.
// - Normal-default pins become input with pull-up.
// - Ready pin also offers input with pull-down.
// - Upper address pins start in normal function.
// - Bus control and ready pins start normal.
// - Strap low at reset enables bus override.
// - Override forces two pins back to normal.
// - Registers sit in one 256-byte block.
// - Narrow writes land as whole 16-bit words at even offsets; writes to odd addresses are ignored.
module pio_bank
  import pio_pkg::*;
#(
  parameter int NPINS = PIO_NUM_PINS
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // Strap sampled at the first edge after reset release, active low
  input  wire logic                  refresh_strap_b,
  // Register port
  input  wire logic [PIO_ADDR_W-1:0] reg_addr,
  input  wire logic [PIO_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [PIO_DATA_W-1:0] reg_rdata,
  // Peripheral side of each pin
  input  wire logic [NPINS-1:0]      periph_out,
  input  wire logic [NPINS-1:0]      periph_oe,
  output logic      [NPINS-1:0]      periph_in,
  // Pad side of each pin
  input  wire logic [NPINS-1:0]      pad_in,
  output logic      [NPINS-1:0]      pad_out,
  output logic      [NPINS-1:0]      pad_oe,
  output logic      [NPINS-1:0]      pad_pullup,
  output logic      [NPINS-1:0]      pad_pulldown,
  // Status
  output logic                       bus_override
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge_half(input logic [31:0] cur,
                                            input logic        hi,
                                            input logic [15:0] val);
    logic [31:0] res;
    res = cur;
    if (hi) begin
      res[31:16] = val;
    end else begin
      res[15:0] = val;
    end
    return res;
  endfunction

  function automatic pio_cfg_t pin_cfg(input logic mode, input logic dir,
                                       input logic normal_dflt, input logic pdn,
                                       input logic pd_ok);
    pio_cfg_t c;
    c = PIO_CFG_NORMAL;
    if (mode && dir) begin
      c = PIO_CFG_OUT_OD;
    end else if (mode) begin
      c = PIO_CFG_OUT;
    end else if (dir && pdn && pd_ok) begin
      c = PIO_CFG_IN_PD;
    end else if (dir) begin
      // Normal-default pins and the rest alike become pulled-up inputs.
      c = PIO_CFG_IN_PU;
    end else if (normal_dflt || !normal_dflt) begin
      c = PIO_CFG_NORMAL;
    end else begin
      c = PIO_CFG_IN;
    end
    return c;
  endfunction

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [31:0]           mode_r;
  logic [31:0]           dir_r;
  logic [31:0]           data_r;
  logic [31:0]           pdn_r;
  logic [31:0]           normal_r;
  logic                  override_r;
  logic                  strap_done_r;
  logic [PIO_DATA_W-1:0] rdata_r;
  logic [31:0]           in_sample_r;
  logic [31:0]           gpio_sel;
  logic                  hi_word;

  assign hi_word   = (reg_addr == PIO_MODE1_OFS) || (reg_addr == PIO_DIR1_OFS) ||
                     (reg_addr == PIO_DATA1_OFS) || (reg_addr == PIO_PULLDN1_OFS);

  // A register pair per pin: mode 0 / dir 0 selects normal function on every pin.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= PIO_MODE_RST;
    end else if (reg_wr && ((reg_addr == PIO_MODE0_OFS) || (reg_addr == PIO_MODE1_OFS))) begin
      mode_r <= merge_half(mode_r, hi_word, reg_wdata);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= PIO_DIR_RST & ~PIO_NORM_RST;
    end else if (reg_wr && ((reg_addr == PIO_DIR0_OFS) || (reg_addr == PIO_DIR1_OFS))) begin
      dir_r <= merge_half(dir_r, hi_word, reg_wdata);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_r <= PIO_DATA_RST;
    end else if (reg_wr && ((reg_addr == PIO_DATA0_OFS) || (reg_addr == PIO_DATA1_OFS))) begin
      data_r <= merge_half(data_r, hi_word, reg_wdata);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pdn_r <= PIO_PDN_RST;
    end else if (reg_wr &&
                 ((reg_addr == PIO_PULLDN0_OFS) || (reg_addr == PIO_PULLDN1_OFS))) begin
      pdn_r <= merge_half(pdn_r, hi_word, reg_wdata);
    end
  end

  // Normal-function default marks are fixed; they gate the pull-down select.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      normal_r <= PIO_NORM_RST;
    end else begin
      normal_r <= normal_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Strap capture at the first edge after reset release
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_r <= 1'b0;
      override_r   <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      override_r   <= ~refresh_strap_b;
    end
  end

  assign bus_override = override_r;

  // ---------------------------------------------------------------------------
  // Per-pin multiplexer
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_sample_r <= 32'h0000_0000;
    end else begin
      in_sample_r <= pad_in;
    end
  end

  always_comb begin
    pio_cfg_t c;
    c            = PIO_CFG_NORMAL;
    gpio_sel     = 32'h0000_0000;
    pad_out      = '0;
    pad_oe       = '0;
    pad_pullup   = '0;
    pad_pulldown = '0;
    periph_in    = '0;
    for (int i = 0; i < NPINS; i++) begin
      c = pin_cfg(mode_r[i], dir_r[i], normal_r[i], pdn_r[i],
                  !normal_r[i] || (i == PIO_READY_PIN));
      if (override_r && PIO_OVR_MASK[i]) begin
        c = PIO_CFG_NORMAL;
      end
      unique case (c)
        PIO_CFG_NORMAL: begin
          pad_out[i]   = periph_out[i];
          pad_oe[i]    = periph_oe[i];
          periph_in[i] = pad_in[i];
        end
        PIO_CFG_IN_PU: begin
          gpio_sel[i]   = 1'b1;
          pad_pullup[i] = 1'b1;
        end
        PIO_CFG_IN_PD: begin
          gpio_sel[i]     = 1'b1;
          pad_pulldown[i] = 1'b1;
        end
        PIO_CFG_IN: begin
          gpio_sel[i] = 1'b1;
        end
        PIO_CFG_OUT: begin
          gpio_sel[i] = 1'b1;
          pad_out[i]  = data_r[i];
          pad_oe[i]   = 1'b1;
        end
        PIO_CFG_OUT_OD: begin
          gpio_sel[i] = 1'b1;
          pad_out[i]  = 1'b0;
          pad_oe[i]   = ~data_r[i];
        end
        default: begin
          gpio_sel[i] = 1'b0;
        end
      endcase
      if (gpio_sel[i]) begin
        periph_in[i] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read port: whole words, data one cycle after the strobe
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PIO_MODE0_OFS:   rdata_r <= mode_r[15:0];
        PIO_MODE1_OFS:   rdata_r <= mode_r[31:16];
        PIO_DIR0_OFS:    rdata_r <= dir_r[15:0];
        PIO_DIR1_OFS:    rdata_r <= dir_r[31:16];
        PIO_DATA0_OFS:   rdata_r <= (data_r[15:0] & ~gpio_sel[15:0]) |
                                    (in_sample_r[15:0] & gpio_sel[15:0]);
        PIO_DATA1_OFS:   rdata_r <= (data_r[31:16] & ~gpio_sel[31:16]) |
                                    (in_sample_r[31:16] & gpio_sel[31:16]);
        PIO_PULLDN0_OFS: rdata_r <= pdn_r[15:0];
        PIO_PULLDN1_OFS: rdata_r <= pdn_r[31:16];
        PIO_STATUS_OFS:  rdata_r <= {15'h0000, override_r};
        default:         rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

//--- tb/pio_chk_sva.sv
// Purpose: Port checker for the pin bank.
// Assumes: One clock, reset active low.
// Notes:   Bound to every pio_bank instance.
`timescale 1ns/1ns
module pio_chk
  import pio_pkg::*;
#(
  parameter int NPINS = PIO_NUM_PINS
) (
  // Clock, reset and strap
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic                  refresh_strap_b,
  // Register port
  input wire logic [PIO_ADDR_W-1:0] reg_addr,
  input wire logic [PIO_DATA_W-1:0] reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [PIO_DATA_W-1:0] reg_rdata,
  // Pins
  input wire logic [NPINS-1:0]      periph_out,
  input wire logic [NPINS-1:0]      periph_oe,
  input wire logic [NPINS-1:0]      periph_in,
  input wire logic [NPINS-1:0]      pad_in,
  input wire logic [NPINS-1:0]      pad_out,
  input wire logic [NPINS-1:0]      pad_oe,
  input wire logic [NPINS-1:0]      pad_pullup,
  input wire logic [NPINS-1:0]      pad_pulldown,
  input wire logic                  bus_override
);
  // --------------------------------
  // Assertions
  // --------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  localparam logic [31:0] NO_PD = PIO_NORM_RST & ~(32'h1 << PIO_READY_PIN);

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside a read");
  a_odd_refused: assert property (reg_rd && reg_addr[0] |=> reg_rdata == '0)
    else $error("odd read returned data");
  a_mode_wrback: assert property ((reg_wr && reg_addr == PIO_MODE0_OFS) ##2
    (reg_rd && reg_addr == PIO_MODE0_OFS) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mode word not read back");
  a_status_read: assert property (reg_rd && reg_addr == PIO_STATUS_OFS
    |=> reg_rdata == 16'(bus_override))
    else $error("status does not show override");
  a_strap_take: assert property ($rose(rst_b) |=> bus_override == !$past(refresh_strap_b))
    else $error("strap not captured");
  a_ovr_steady: assert property (rst_b && $past(rst_b) |=> $stable(bus_override))
    else $error("override changed after capture");
  a_boot_normal: assert property ($rose(rst_b) |->
    (((pad_oe ^ periph_oe) | (pad_out ^ periph_out)) & PIO_NORM_RST) == '0)
    else $error("bus pins not normal after reset");
  a_ovr_pins: assert property (bus_override |->
    (((pad_oe ^ periph_oe) | (periph_in ^ pad_in)) & PIO_OVR_MASK) == '0)
    else $error("override pins not normal");
  a_pull_legal: assert property (((pad_pullup & pad_pulldown) | (pad_pulldown & NO_PD)) == '0)
    else $error("illegal pull-down");
  a_pulled_input: assert property (((pad_pullup | pad_pulldown) & (pad_oe | periph_in)) == '0)
    else $error("pulled pin driven or passed on");

  c_override: cover property (bus_override);
  c_wr_rd: cover property (reg_wr ##2 reg_rd);
  c_push_pull: cover property (|(pad_oe & ~periph_oe));
endmodule

bind pio_bank pio_chk #(.NPINS(NPINS)) pio_chk_inst (
  .core_clk(core_clk), .rst_b(rst_b), .refresh_strap_b(refresh_strap_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .periph_out(periph_out), .periph_oe(periph_oe),
  .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .bus_override(bus_override));

//--- tb/tb_top.sv
// Purpose: Directed bench for the pin bank.
// Assumes: Bench drives pads and peripheral side.
// Notes:   Ends through final_report.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_top
  import pio_pkg::*;
;
  logic        core_clk, rst_b, refresh_strap_b, reg_wr, reg_rd, bus_override;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [31:0] periph_out, periph_oe, periph_in, pad_in, pad_out, pad_oe;
  logic [31:0] pad_pullup, pad_pulldown;
  int          n_errors, compares, cycles;

  pio_bank pio_bank_inst (
    .core_clk(core_clk), .rst_b(rst_b), .refresh_strap_b(refresh_strap_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .bus_override(bus_override));

  // --------------------------------
  // Bus tasks and scenarios
  // --------------------------------
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task do_reset(input logic strap);
    rst_b <= 1'b0;
    refresh_strap_b <= strap;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task t_defaults;
    logic [7:0]  ra [5];
    logic [15:0] ex [5];
    ra = '{PIO_MODE0_OFS, PIO_MODE1_OFS, PIO_DIR0_OFS, PIO_DIR1_OFS, PIO_PULLDN0_OFS};
    ex = '{16'h0000, 16'h0000, ~PIO_NORM_RST[15:0], 16'hffff, PIO_PDN_RST[15:0]};
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], rv);
      `CHK(rv, ex[i])
    end
    #1;
    `CHK(pad_oe, periph_oe & PIO_NORM_RST)
    `CHK(pad_out & PIO_NORM_RST, periph_out & PIO_NORM_RST)
    `CHK(periph_in, pad_in & PIO_NORM_RST)
    `CHK(pad_pullup, ~(PIO_NORM_RST | PIO_PDN_RST))
    `CHK(pad_pulldown, PIO_PDN_RST)
    @(posedge core_clk);
  endtask
  task t_outputs;
    rd(8'h71, rv);
    `CHK(rv, 16'h0000)
    wr(8'h71, 16'hffff);
    rd(PIO_MODE0_OFS, rv);
    `CHK(rv, 16'h0000)
    wr(PIO_MODE0_OFS, 16'h0001);
    rd(PIO_MODE0_OFS, rv);
    `CHK(rv, 16'h0001)
    `CHK({pad_oe[0], pad_out[0], periph_in[0]}, 3'b100)
    wr(PIO_DATA0_OFS, 16'h0001);
    #1;
    `CHK(pad_oe[0], 1'b0)
    @(posedge core_clk);
    wr(PIO_DIR0_OFS, 16'hfc06);
    #1;
    `CHK({pad_oe[0], pad_out[0], pad_pullup[0]}, 3'b110)
    @(posedge core_clk);
  endtask
  task t_inputs;
    wr(PIO_DIR0_OFS, 16'hfc56);
    wr(PIO_PULLDN0_OFS, 16'h0452);
    rd(PIO_PULLDN0_OFS, rv);
    `CHK(rv, 16'h0452)
    rd(PIO_DATA0_OFS, rv);
    `CHK(rv & 16'h0050, 16'h0050)
    `CHK({pad_pullup[4], pad_pulldown[4], pad_oe[4], periph_in[4]}, 4'b1000)
    `CHK({pad_pullup[6], pad_pulldown[6]}, 2'b01)
  endtask
  task t_upper;
    wr(PIO_MODE1_OFS, 16'h8000);
    wr(PIO_DIR1_OFS, 16'h7fff);
    wr(PIO_DATA1_OFS, 16'h8000);
    rd(PIO_DIR1_OFS, rv);
    `CHK(rv, 16'h7fff)
    `CHK({pad_oe[31], pad_out[31], periph_in[31]}, 3'b110)
    `CHK(pad_oe[30:16], 15'h0000)
  endtask
  task t_override;
    do_reset(1'b0);
    `CHK(bus_override, 1'b1)
    rd(PIO_STATUS_OFS, rv);
    `CHK(rv, 16'h0001)
    rd(PIO_MODE1_OFS, rv);
    `CHK(rv, 16'h0000)
    `CHK(pad_oe & PIO_OVR_MASK, periph_oe & PIO_OVR_MASK)
    `CHK(periph_in & PIO_OVR_MASK, pad_in & PIO_OVR_MASK)
  endtask
  task final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd, refresh_strap_b} = 4'b0001;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    periph_out = 32'ha5a5_5a5a;
    periph_oe = 32'h3c3c_c3c3;
    pad_in = 32'h0f0f_f0f0;
    @(posedge core_clk);
    do_reset(1'b1);
    t_defaults();
    t_outputs();
    t_inputs();
    t_upper();
    t_override();
    final_report();
  end
endmodule
